// ==== hw/raas_regs.vh ====
`ifndef RAAS_REGS_VH
`define RAAS_REGS_VH
// ****************************************
// instruction word layout
// ****************************************
`define RAAS_OPC_HI 15
`define RAAS_OPC_LO 10
`define RAAS_SRC_HI 9
`define RAAS_SRC_LO 5
`define RAAS_DST_HI 4
`define RAAS_DST_LO 0
// ****************************************
// opcodes
// ****************************************
`define RAAS_OP_ADD 6'h00
`define RAAS_OP_CARRY_SUM 6'h01
`define RAAS_OP_QUICK_SUM 6'h02
`define RAAS_OP_MAGNITUDE 6'h16
`define RAAS_OP_QUICK_WRAPPED 6'h3F
// ****************************************
// reset values and pipeline timing
// ****************************************
`define RAAS_WRAP_MASK_RESET 32'h0000_0000
`define RAAS_MAG_WB_CYCLE 2
`define RAAS_ADD_WB_CYCLE 3
`endif

// ==== hw/raas_regfile.v ====
`timescale 1ns/10ps
// ****************************************
// register file: two read ports, one write port
// ****************************************
module raas_regfile (
  input wire clk,
  input wire [4:0] rd_addr_a,
  input wire [4:0] rd_addr_b,
  output reg [31:0] rd_data_a,
  output reg [31:0] rd_data_b,
  input wire wr_en,
  input wire [4:0] wr_addr,
  input wire [31:0] wr_data
);
  reg [31:0] mem [0:31]; // 32 general registers

  // registered reads; no reset, contents undefined until written
  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    // write-through: a word taken on the write edge must see the new value
    rd_data_a <= (wr_en && (wr_addr == rd_addr_a)) ? wr_data : mem[rd_addr_a];
    rd_data_b <= (wr_en && (wr_addr == rd_addr_b)) ? wr_data : mem[rd_addr_b];
  end
endmodule

// ==== hw/raas_alu_slice.v ====
`timescale 1ns/10ps
`include "raas_regs.vh"
module raas_alu_slice #(
  parameter HAS_WRAPPED_OP = 1 // audio-side build carries opcode 63
) (
  input wire clk,
  input wire resetn,
  input wire issue_valid,
  input wire [15:0] issue_word,
  input wire [31:0] wrap_mask_register,
  output reg issue_ready,
  output reg wb_valid,
  output reg [4:0] wb_addr,
  output reg [31:0] wb_data,
  output reg flag_z,
  output reg flag_n,
  output reg flag_c,
  output reg flags_valid,
  output reg illegal_op
);
  // ****************************************
  // reset release
  // ****************************************
  reg rst_meta; // first stage, read only by rst_sync
  reg rst_sync; // released reset used by the state and output flops

  // two-flop release of the async reset
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // ****************************************
  // decode helpers
  // ****************************************
  // known opcode check, used on issue by sequencing and illegal_op
  function is_known;
    input [5:0] op;
    begin
      is_known = (op == `RAAS_OP_ADD) || (op == `RAAS_OP_CARRY_SUM) ||
                 (op == `RAAS_OP_QUICK_SUM) || (op == `RAAS_OP_MAGNITUDE) ||
                 ((op == `RAAS_OP_QUICK_WRAPPED) && (HAS_WRAPPED_OP != 0));
    end
  endfunction

  // immediate from source field, zero stands for 32
  function [31:0] quick_imm;
    input [4:0] f;
    begin
      quick_imm = (f == 5'h00) ? 32'h0000_0020 : {27'h000_0000, f};
    end
  endfunction

  // ****************************************
  // pipeline state
  // ****************************************
  localparam ST_IDLE = 2'd0; // accepting a word
  localparam ST_EXEC = 2'd1; // cycle 1: operands read
  localparam ST_ADD2 = 2'd2; // cycle 2 of an add
  reg [1:0] state;
  reg [1:0] next_state;
  reg [5:0] op_q; // opcode in flight
  reg [4:0] src_q; // source field in flight
  reg [4:0] dst_q; // target field in flight
  reg [31:0] sum_q; // adder result held for cycle 3
  reg z_q;
  reg n_q;
  reg c_q;

  wire [5:0] in_op = issue_word[`RAAS_OPC_HI:`RAAS_OPC_LO];
  wire [4:0] in_src = issue_word[`RAAS_SRC_HI:`RAAS_SRC_LO];
  wire [4:0] in_dst = issue_word[`RAAS_DST_HI:`RAAS_DST_LO];
  wire take = issue_valid && issue_ready && (state == ST_IDLE);

  // ****************************************
  // register file
  // ****************************************
  wire [31:0] rf_dst; // target operand, valid in cycle 1
  wire [31:0] rf_src; // source operand, valid in cycle 1
  wire rf_we = wb_valid; // write port follows the result
  raas_regfile u_rf (
    .clk(clk),
    .rd_addr_a(in_dst),
    .rd_addr_b(in_src),
    .rd_data_a(rf_dst),
    .rd_data_b(rf_src),
    .wr_en(rf_we),
    .wr_addr(wb_addr),
    .wr_data(wb_data)
  );

  // ****************************************
  // execute datapath (cycle 1)
  // ****************************************
  reg [32:0] add_full; // sum with carry out
  reg [31:0] addend; // second operand of the adder
  reg carry_in;
  reg [31:0] mag; // magnitude result
  reg [31:0] res; // final add result incl. mask

  always @* begin
    addend = rf_src;
    carry_in = 1'b0;
    case (op_q)
      `RAAS_OP_CARRY_SUM: begin
        carry_in = flag_c;
      end
      `RAAS_OP_QUICK_SUM, `RAAS_OP_QUICK_WRAPPED: begin
        addend = quick_imm(src_q);
      end
      default: begin
        addend = rf_src;
      end
    endcase
    add_full = {1'b0, rf_dst} + {1'b0, addend} + {32'h0000_0000, carry_in};
    // negation wraps, so the most negative value stays itself
    mag = rf_dst[31] ? (~rf_dst + 32'h0000_0001) : rf_dst;
    res = add_full[31:0];
    if (op_q == `RAAS_OP_QUICK_WRAPPED) begin
      // masked bits keep the old value; carry still comes from the raw adder
      res = (rf_dst & wrap_mask_register) | (add_full[31:0] & ~wrap_mask_register);
    end
  end

  // ****************************************
  // sequencing
  // ****************************************
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        // an idle or unknown word occupies no later stage
        if (take && is_known(in_op)) begin
          next_state = ST_EXEC;
        end
      end
      ST_EXEC: begin
        next_state = (op_q == `RAAS_OP_MAGNITUDE) ? ST_IDLE : ST_ADD2;
      end
      ST_ADD2: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // state, capture and write-back; all outputs registered
  always @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      state <= ST_IDLE;
      op_q <= 6'h00;
      src_q <= 5'h00;
      dst_q <= 5'h00;
      sum_q <= 32'h0000_0000;
      z_q <= 1'b0;
      n_q <= 1'b0;
      c_q <= 1'b0;
      issue_ready <= 1'b0;
      wb_valid <= 1'b0;
      wb_addr <= 5'h00;
      wb_data <= 32'h0000_0000;
      flag_z <= 1'b0;
      flag_n <= 1'b0;
      flag_c <= 1'b0;
      flags_valid <= 1'b0;
      illegal_op <= 1'b0;
    end else begin
      state <= next_state;
      wb_valid <= 1'b0;
      flags_valid <= 1'b0;
      illegal_op <= 1'b0;
      issue_ready <= (next_state == ST_IDLE);
      if (take) begin
        op_q <= in_op;
        src_q <= in_src;
        dst_q <= in_dst;
        illegal_op <= !is_known(in_op);
      end
      case (state)
        ST_EXEC: begin
          if (op_q == `RAAS_OP_MAGNITUDE) begin
            // result and flags land together in cycle 2
            wb_valid <= 1'b1;
            wb_addr <= dst_q;
            wb_data <= mag;
            flag_z <= (mag == 32'h0000_0000);
            // cleared for every result but the most negative one, which stays negative
            flag_n <= mag[31];
            flag_c <= rf_dst[31];
            flags_valid <= 1'b1;
          end else begin
            sum_q <= res;
            z_q <= (res == 32'h0000_0000);
            n_q <= res[31];
            c_q <= add_full[32];
          end
        end
        ST_ADD2: begin
          wb_valid <= 1'b1;
          wb_addr <= dst_q;
          wb_data <= sum_q;
          flag_z <= z_q;
          flag_n <= n_q;
          flag_c <= c_q;
          flags_valid <= 1'b1;
        end
        default: begin
          wb_valid <= 1'b0;
        end
      endcase
    end
  end
endmodule

// ==== tb/raas_alu_monitor.sv ====
`timescale 1ns/10ps
`include "raas_regs.vh"
module raas_alu_monitor #(parameter HAS_WRAPPED_OP = 1) (
  input wire clk,
  input wire resetn,
  input wire issue_valid,
  input wire [15:0] issue_word,
  input wire issue_ready,
  input wire wb_valid,
  input wire [4:0] wb_addr,
  input wire [31:0] wb_data,
  input wire flag_z,
  input wire flag_n,
  input wire flags_valid,
  input wire illegal_op
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  wire [5:0] op = issue_word[15:10];
  wire take = issue_valid && issue_ready;
  wire mag = op == `RAAS_OP_MAGNITUDE;
  wire add = op <= `RAAS_OP_QUICK_SUM || (op == `RAAS_OP_QUICK_WRAPPED && HAS_WRAPPED_OP != 0);
  wire bad_take = take && !mag && !add; // unknown opcode accepted
  a_mag_wb_cycle: assert property (take && mag |=> (!wb_valid && !issue_ready)
    ##1 (wb_valid && wb_addr == $past(issue_word[4:0], 2))) else $error("magnitude writeback off");
  a_add_wb_cycle: assert property (take && add |=> !wb_valid [*2]
    ##1 (wb_valid && wb_addr == $past(issue_word[4:0], 3))) else $error("add writeback off");
  a_flags_with_wb: assert property (flags_valid == wb_valid) else $error("flags not with result");
  a_flags_hold: assert property (!wb_valid |-> $stable({flag_z, flag_n})) else $error("flags moved");
  a_mag_flags: assert property (take && mag |-> ##2 (flag_n == wb_data[31] && flag_z == (wb_data == 0)))
    else $error("magnitude flags wrong");
  a_mag_sign: assert property (take && mag |-> ##2 (!wb_data[31] || wb_data == 32'h8000_0000))
    else $error("magnitude result negative");
  a_add_zn: assert property (take && add |-> ##3 (flag_z == (wb_data == 0) && flag_n == wb_data[31]))
    else $error("add flags wrong");
  a_busy_refuse: assert property (take && (mag || add) |=> !issue_ready) else $error("ready while busy");
  a_illegal_pulse: assert property (bad_take |=> illegal_op && !wb_valid) else $error("no illegal");
  a_illegal_cause: assert property (illegal_op |-> $past(bad_take)) else $error("stray illegal");
  c_mag: cover property (take && mag);
  c_wrap: cover property (take && op == `RAAS_OP_QUICK_WRAPPED);
  c_bad: cover property (illegal_op);
  c_add: cover property (take && add);
endmodule
bind raas_alu_slice raas_alu_monitor #(.HAS_WRAPPED_OP(HAS_WRAPPED_OP)) raas_alu_monitor_inst (.clk(clk),
  .resetn(resetn), .issue_valid(issue_valid), .issue_word(issue_word), .issue_ready(issue_ready),
  .wb_valid(wb_valid), .wb_addr(wb_addr), .wb_data(wb_data), .flag_z(flag_z), .flag_n(flag_n),
  .flags_valid(flags_valid), .illegal_op(illegal_op));

// ==== tb/raas_seq_model.sv ====
`timescale 1ns/10ps
`include "raas_regs.vh"
// instruction sequencer: waits for ready, then offers one word for a single cycle
module raas_seq_model (
  input wire clk,
  input wire issue_ready,
  output logic issue_valid,
  output logic [15:0] issue_word
);
  initial begin
    issue_valid = 1'b0;
    issue_word = 16'h0000;
  end
  task send(input [15:0] w);
    reg [15:0] v;
    begin
      v = (w[15:10] == `RAAS_OP_MAGNITUDE) ? {w[15:10], 5'h00, w[4:0]} : w;
      do @(posedge clk); while (issue_ready !== 1'b1);
      issue_valid <= 1'b1;
      issue_word <= v;
      @(posedge clk);
      issue_valid <= 1'b0;
      issue_word <= ~v; // released word toggles, never looks valid
    end
  endtask
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/10ps
`include "raas_regs.vh"
module tb_top;
  logic clk, resetn;
  logic [31:0] wrap_mask_register;
  wire issue_valid, issue_ready, wb_valid, flag_z, flag_n, flag_c, flags_valid, illegal_op;
  wire [15:0] issue_word;
  wire [4:0] wb_addr;
  wire [31:0] wb_data;
  integer fail_count, comparisons, seed, bad_seen, i;
  logic [31:0] shadow [0:31]; // expected register contents
  logic carry;
  logic [36:0] expq [$]; // {low 2 addr bits, z, n, c, data}
  logic [5:0] ops [0:4];
  raas_alu_slice raas_alu_slice_inst (.clk(clk), .resetn(resetn), .issue_valid(issue_valid),
    .issue_word(issue_word), .wrap_mask_register(wrap_mask_register), .issue_ready(issue_ready),
    .wb_valid(wb_valid), .wb_addr(wb_addr), .wb_data(wb_data), .flag_z(flag_z), .flag_n(flag_n),
    .flag_c(flag_c), .flags_valid(flags_valid), .illegal_op(illegal_op));
  raas_seq_model raas_seq_model_inst (.clk(clk), .issue_ready(issue_ready), .issue_valid(issue_valid),
    .issue_word(issue_word));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task check(input [36:0] seen, input [36:0] want);
    begin
      comparisons = comparisons + 1;
      if (seen !== want) begin
        fail_count = fail_count + 1;
        $display("MISMATCH t=%0t seen %h want %h", $time, seen, want);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  // model one instruction, note the result, then issue it
  task run(input [5:0] op, input [4:0] s, input [4:0] d, input [31:0] m);
    reg [31:0] a, imm, res;
    reg c;
    begin
      @(posedge clk);
      while (issue_ready !== 1'b1) @(posedge clk);
      wrap_mask_register <= m; // only changed with nothing in flight
      a = shadow[d];
      imm = (s == 5'h00) ? 32'd32 : {27'h0, s};
      c = 1'b0;
      case (op)
        `RAAS_OP_MAGNITUDE: begin
          res = a[31] ? -a : a;
          c = a[31];
        end
        `RAAS_OP_ADD: {c, res} = a + shadow[s];
        `RAAS_OP_CARRY_SUM: {c, res} = a + shadow[s] + carry;
        `RAAS_OP_QUICK_SUM: {c, res} = a + imm;
        default: begin
          {c, res} = a + imm;
          res = (res & ~m) | (a & m);
        end
      endcase
      shadow[d] = res;
      carry = c;
      expq.push_back({d, res == 0, res[31], c, res});
      raas_seq_model_inst.send({op, s, d});
    end
  endtask
  // result watcher
  always @(posedge clk) begin
    if (illegal_op === 1'b1) bad_seen = bad_seen + 1;
    if (wb_valid === 1'b1) begin
      if (expq.size() == 0) check(37'h0, 37'h1);
      else check({wb_addr, flag_z, flag_n, flag_c, wb_data}, expq.pop_front());
    end
  end
  initial begin
    #400000;
    fail_count = fail_count + 1;
    give_verdict;
  end
  initial begin
    ops = '{6'h00, 6'h01, 6'h02, 6'h16, 6'h3F};
    seed = 32'hd50f;
    fail_count = 0;
    comparisons = 0;
    bad_seen = 0;
    carry = 1'b0;
    resetn = 1'b0;
    wrap_mask_register = 32'h0000_0000;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    for (i = 0; i < 32; i = i + 1) shadow[i] = $random(seed);
    shadow[1] = 32'h8000_0000;
    shadow[2] = 32'h0000_0000;
    shadow[3] = 32'hFFFF_FFFF;
    for (i = 0; i < 32; i = i + 1) raas_alu_slice_inst.u_rf.mem[i] = shadow[i];
    run(6'h16, 5'h07, 5'h01, 32'h0000_0000);
    run(6'h16, 5'h00, 5'h02, 32'h0000_0000);
    run(6'h16, 5'h00, 5'h03, 32'h0000_0000);
    run(6'h02, 5'h00, 5'h03, 32'h0000_0000);
    run(6'h02, 5'h1F, 5'h03, 32'h0000_0000);
    run(6'h3F, 5'h1F, 5'h03, 32'hFFFF_FFF0);
    $display("test edge values done");
    for (i = 0; i < 60; i = i + 1) run(ops[$unsigned($random(seed)) % 5], $random(seed), $random(seed), $random(seed));
    $display("test random mix done");
    raas_seq_model_inst.send(16'h1403);
    raas_seq_model_inst.send(16'h2C00);
    repeat (6) @(posedge clk);
    check(37'(bad_seen), 37'd2);
    check(37'(expq.size()), 37'd0);
    $display("test unknown opcodes done");
    give_verdict;
  end
endmodule
